/* logic/dac_audio_input.sv */
// serial audio receiver, power-on init, clock supervision and zero flags
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dac_audio_input
   import dac_front_pkg::*;
#(
   parameter bit PIN_VARIANT = 1'b0,
   parameter int INIT_CYCLES = INIT_MCLK_CYCLES,
   parameter int ZERO_RUN = ZERO_RUN_WORDS,
   parameter int GAP_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic master_clock,
   input wire logic serial_bit_clock,
   input wire logic channel_word_clock,
   input wire logic serial_data,
   input wire logic framing_select_pin,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output sample_pair_type dac_samples,
   output logic sample_strobe,
   output logic init_active,
   output logic processing_held,
   output logic left_zero_flag,
   output logic right_zero_flag,
   output logic common_zero_flag
);
   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

   if (INIT_CYCLES < 1 || GAP_W < 8 || ZERO_RUN < 1) begin : bad_param
      $error("init count, zero run or gap width out of range");
   end

   // ratio lookup: nearest table entry within tolerance
   function automatic logic [2:0] ratio_lookup(input logic [11:0] cnt);
      logic [2:0] code;
      code = RATIO_NONE;
      for (int i = 0; i < NUM_RATIOS; i++) begin
         if (cnt + RATIO_TOL >= RATIO_TABLE[i] &&
             cnt <= RATIO_TABLE[i] + RATIO_TOL) begin
            code = 3'(i);
         end
      end
      return code;
   endfunction

   // sample width of a right-justified framing, zero for the others
   function automatic logic [4:0] rj_width(input logic [2:0] fmt);
      logic [4:0] w;
      unique case (fmt)
         FMT_RJ24: w = 5'h18;
         FMT_RJ20: w = 5'h14;
         FMT_RJ18: w = 5'h12;
         FMT_RJ16: w = 5'h10;
         default: w = 5'h00;
      endcase
      return w;
   endfunction

   // --- pin synchronisers: meta stage feeds only the sync stage
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;
   logic [1:0] prev_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 4'h0;
         sync_reg <= 4'h0;
         prev_reg <= 2'h0;
      end else begin
         meta_reg <= {master_clock, serial_bit_clock,
                      channel_word_clock, serial_data};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg[3:2];
      end
   end

   // the format pin is a static strap but still crosses two stages
   logic [1:0] fmt_pin_sync_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fmt_pin_sync_reg <= 2'h0;
      end else begin
         fmt_pin_sync_reg <= {fmt_pin_sync_reg[0], framing_select_pin};
      end
   end

   wire mclk_rise = sync_reg[3] & ~prev_reg[1];
   wire bck_rise = sync_reg[2] & ~prev_reg[0];
   wire word_level = sync_reg[1];
   wire data_bit = sync_reg[0];

   // --- control register and effective framing
   ctrl_type ctrl_reg;
   wire [2:0] pin_fmt = fmt_pin_sync_reg[1] ? FMT_RJ16 : FMT_I2S;
   wire [2:0] fmt = PIN_VARIANT ? pin_fmt : ctrl_reg.framing;
   wire is_i2s = (fmt == FMT_I2S);
   wire is_rj = (rj_width(fmt) != 5'h00);

   // --- word clock level seen at each bit clock rise
   logic word_prev_reg;
   wire word_edge = bck_rise & (word_level != word_prev_reg);
   wire frame_edge = word_edge & word_level;
   // the half just ended belongs to left when its level marks left
   wire ended_left = is_i2s ? ~word_prev_reg : word_prev_reg;

   // --- bit counter and capture window per half frame
   logic [6:0] bit_idx_reg;
   logic [31:0] shift_reg;
   logic [SAMPLE_W-1:0] cap_reg;
   logic [4:0] cap_cnt_reg;
   wire [6:0] idx_now = word_edge ? 7'h00 : bit_idx_reg;
   // i2s msb trails the word edge by one bit, left-justified sits on it
   wire [6:0] win_lo = is_i2s ? 7'h01 : 7'h00;
   wire in_window = !is_rj && idx_now >= win_lo &&
                    idx_now < win_lo + 7'(SAMPLE_W);

   // msb first: older bits move up as new ones arrive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_prev_reg <= 1'b0;
         bit_idx_reg <= 7'h00;
         shift_reg <= 32'h0000_0000;
      end else if (bck_rise) begin
         word_prev_reg <= word_level;
         bit_idx_reg <= (idx_now == 7'h7f) ? idx_now : idx_now + 7'h01;
         shift_reg <= {shift_reg[30:0], data_bit};
      end
   end

   // capture restarts at each word edge, so it never mixes channels
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_reg <= '0;
         cap_cnt_reg <= 5'h00;
      end else if (bck_rise) begin
         if (word_edge) begin
            cap_reg <= in_window ? SAMPLE_W'(data_bit) : '0;
            cap_cnt_reg <= in_window ? 5'h01 : 5'h00;
         end else if (in_window) begin
            cap_reg <= {cap_reg[SAMPLE_W-2:0], data_bit};
            cap_cnt_reg <= cap_cnt_reg + 5'h01;
         end
      end
   end

   // sample of the ended half, msb aligned to the converter width
   wire [4:0] rj_w = rj_width(fmt);
   wire [SAMPLE_W-1:0] rj_sample =
      shift_reg[SAMPLE_W-1:0] << (5'(SAMPLE_W) - rj_w);
   wire [SAMPLE_W-1:0] lj_sample =
      cap_reg << (5'(SAMPLE_W) - cap_cnt_reg);
   wire [SAMPLE_W-1:0] ended_sample = is_rj ? rj_sample : lj_sample;
   wire ended_zero = (ended_sample == '0);

   // --- clock supervision: gaps measured against last bit period
   logic [GAP_W-1:0] bck_gap_reg;
   logic [GAP_W-1:0] bck_period_reg;
   logic [GAP_W-1:0] mclk_gap_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bck_gap_reg <= '0;
         bck_period_reg <= '0;
         mclk_gap_reg <= '0;
      end else begin
         bck_gap_reg <= bck_rise ? '0 :
                        (&bck_gap_reg) ? bck_gap_reg : bck_gap_reg + 1'b1;
         mclk_gap_reg <= mclk_rise ? '0 :
                         (&mclk_gap_reg) ? mclk_gap_reg : mclk_gap_reg + 1'b1;
         if (bck_rise) begin
            bck_period_reg <= bck_gap_reg + 1'b1;
         end
      end
   end

   // product widened so a long bit period cannot wrap the limit
   wire [GAP_W+1:0] stall_limit =
      (GAP_W+2)'(bck_period_reg) * (GAP_W+2)'(STALL_BIT_PERIODS);
   wire stalled = (bck_period_reg == '0) ||
                  ((GAP_W+2)'(bck_gap_reg) >= stall_limit) ||
                  ((GAP_W+2)'(mclk_gap_reg) >= stall_limit);

   // --- per-frame measurements: bits for rate, master clocks for ratio
   logic [6:0] frame_bits_reg;
   logic [6:0] last_bits_reg;
   logic [11:0] mclk_cnt_reg;
   logic [2:0] ratio_reg;
   wire rate_change = (frame_bits_reg != last_bits_reg);
   wire [2:0] ratio_now = ratio_lookup(mclk_cnt_reg);
   wire ratio_bad = (ratio_now == RATIO_NONE);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_bits_reg <= 7'h00;
         last_bits_reg <= 7'h00;
         mclk_cnt_reg <= 12'h000;
         ratio_reg <= RATIO_NONE;
      end else begin
         if (frame_edge) begin
            frame_bits_reg <= 7'h01;
            last_bits_reg <= frame_bits_reg;
            ratio_reg <= ratio_now;
         end else if (bck_rise && frame_bits_reg != 7'h7f) begin
            frame_bits_reg <= frame_bits_reg + 7'h01;
         end
         if (frame_edge) begin
            mclk_cnt_reg <= 12'(mclk_rise);
         end else if (mclk_rise && mclk_cnt_reg != 12'hfff) begin
            mclk_cnt_reg <= mclk_cnt_reg + 12'h001;
         end
      end
   end

   // --- sequencer
   seq_state_type state_reg;
   seq_state_type state_next;
   logic [INIT_W-1:0] init_cnt_reg;
   logic [1:0] good_reg;
   wire frame_ok = !rate_change && !ratio_bad;
   wire init_done = mclk_rise && (init_cnt_reg == INIT_LAST);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_INIT: if (init_done) state_next = ST_SYNC;
         ST_SYNC: begin
            if (stalled) begin
               state_next = ST_HOLD;
            // first whole frame only needs a valid ratio, so resync
            // lands within two word periods of the clocks resuming
            end else if (frame_edge && !ratio_bad &&
                         good_reg == RESYNC_WORDS - 2'h1) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stalled || (frame_edge && !frame_ok)) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: if (!stalled) state_next = ST_SYNC;
      endcase
   end

   // init counts master clock edges, not system clocks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_INIT;
         init_cnt_reg <= '0;
         good_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_INIT && mclk_rise) begin
            init_cnt_reg <= init_cnt_reg + 1'b1;
         end
         if (state_reg != ST_SYNC) begin
            good_reg <= 2'h0;
         end else if (frame_edge) begin
            good_reg <= 2'h1;
         end
      end
   end

   wire running = (state_reg == ST_RUN);

   // --- holding registers; mid-scale zero whenever not running
   wire load_left = running & word_edge & ended_left;
   wire load_right = running & word_edge & ~ended_left;
   logic left_was_zero_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dac_samples <= '0;
         sample_strobe <= 1'b0;
         left_was_zero_reg <= 1'b0;
      end else begin
         sample_strobe <= load_right;
         if (!running) begin
            dac_samples <= '0;
         end else if (load_left) begin
            dac_samples.left <= ended_sample;
            left_was_zero_reg <= ended_zero;
         end else if (load_right) begin
            dac_samples.right <= ended_sample;
         end
      end
   end

   // --- zero-run detectors: one per channel and one for the pair
   logic left_hit;
   logic right_hit;
   logic common_hit;
   zero_run_detect #(.RUN_LEN(ZERO_RUN)) left_det (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_strobe(load_left),
      .sample_is_zero(ended_zero),
      .zero_hit(left_hit)
   );
   zero_run_detect #(.RUN_LEN(ZERO_RUN)) right_det (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_strobe(load_right),
      .sample_is_zero(ended_zero),
      .zero_hit(right_hit)
   );
   // pair counted once per word period, at the right sample
   zero_run_detect #(.RUN_LEN(ZERO_RUN)) common_det (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_strobe(load_right),
      .sample_is_zero(ended_zero & left_was_zero_reg),
      .zero_hit(common_hit)
   );

   // flag routing: pin variant has only the common flag, active high
   wire flag_inv = !PIN_VARIANT && ctrl_reg.polarity_invert;
   wire use_common = !PIN_VARIANT && ctrl_reg.common_select;
   wire left_raw = use_common ? common_hit : left_hit;
   wire right_raw = use_common ? common_hit : right_hit;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         left_zero_flag <= 1'b0;
         right_zero_flag <= 1'b0;
         common_zero_flag <= 1'b0;
      end else begin
         left_zero_flag <= !PIN_VARIANT && (left_raw ^ flag_inv);
         right_zero_flag <= !PIN_VARIANT && (right_raw ^ flag_inv);
         common_zero_flag <= common_hit ^ flag_inv;
      end
   end

   assign init_active = (state_reg == ST_INIT);
   assign processing_held = !running;

   // --- register port: write one cycle, read data the cycle after only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= '{common_select: 1'b0, polarity_invert: 1'b0,
                       framing: FMT_RESET};
      end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
         ctrl_reg.framing <= reg_wdata[CTRL_FMT_LSB +: 3];
         ctrl_reg.polarity_invert <= reg_wdata[CTRL_INV_BIT];
         ctrl_reg.common_select <= reg_wdata[CTRL_COMMON_BIT];
      end
   end

   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STAT_RATIO_LSB +: 3] = ratio_reg;
      status_word[STAT_STATE_LSB +: 2] = state_reg;
      status_word[STAT_LZERO_BIT] = left_hit;
      status_word[STAT_RZERO_BIT] = right_hit;
      status_word[STAT_CZERO_BIT] = common_hit;
   end

   // unmapped addresses read as zero
   wire [31:0] ctrl_word = 32'({ctrl_reg.common_select,
                                ctrl_reg.polarity_invert, 1'b0,
                                ctrl_reg.framing});
   wire [31:0] rd_mux =
      (reg_addr == ADDR_CONTROL) ? ctrl_word :
      (reg_addr == ADDR_STATUS) ? status_word :
      (reg_addr == ADDR_LEFT) ? 32'(dac_samples.left) :
      (reg_addr == ADDR_RIGHT) ? 32'(dac_samples.right) : 32'h0000_0000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

/* logic/dac_front_pkg.sv */
// shared constants, types and register layout of the audio input front end
package dac_front_pkg;

   // sample width carried to the converter core
   localparam int SAMPLE_W = 24;

   // register byte addresses on the plain register port
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_LEFT = 4'h8;
   localparam logic [3:0] ADDR_RIGHT = 4'hc;

   // control register field positions
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_INV_BIT = 4;
   localparam int CTRL_COMMON_BIT = 5;

   // status register field positions
   localparam int STAT_RATIO_LSB = 0;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_LZERO_BIT = 8;
   localparam int STAT_RZERO_BIT = 9;
   localparam int STAT_CZERO_BIT = 10;

   // framing codes of the three-bit format field
   typedef enum logic [2:0] {
      FMT_RJ24 = 3'h0,
      FMT_RJ20 = 3'h1,
      FMT_RJ18 = 3'h2,
      FMT_RJ16 = 3'h3,
      FMT_I2S = 3'h4,
      FMT_LJ24 = 3'h5
   } framing_type;
   localparam framing_type FMT_RESET = FMT_LJ24;

   // supported master clock ratios, index is the reported ratio code
   localparam int NUM_RATIOS = 7;
   localparam logic [11:0] RATIO_TABLE [NUM_RATIOS] = '{
      12'h080, 12'h0c0, 12'h100, 12'h180, 12'h200, 12'h300, 12'h480};
   localparam logic [11:0] RATIO_TOL = 12'h004;
   localparam logic [2:0] RATIO_NONE = 3'h7;

   // timing counts
   localparam int INIT_MCLK_CYCLES = 1024;
   localparam int ZERO_RUN_WORDS = 1024;
   localparam int STALL_BIT_PERIODS = 3;
   localparam logic [1:0] RESYNC_WORDS = 2'h2;

   // sequencer states, gray along init -> sync -> run -> hold
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_SYNC = 2'b01,
      ST_RUN = 2'b11,
      ST_HOLD = 2'b10
   } seq_state_type;

   // control register contents
   typedef struct packed {
      logic common_select;
      logic polarity_invert;
      logic [2:0] framing;
   } ctrl_type;

   // one stereo sample pair, two's complement
   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } sample_pair_type;

endpackage

/* logic/zero_run_detect.sv */
// counts consecutive zero samples on one stream and flags a long run
`timescale 1ns/1ps
module zero_run_detect #(
   parameter int RUN_LEN = 1024
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sample_strobe,
   input wire logic sample_is_zero,
   output logic zero_hit
);
   localparam int CNT_W = $clog2(RUN_LEN + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(RUN_LEN - 1);

   if (RUN_LEN < 1) begin : bad_len
      $error("zero run length must be at least one");
   end

   logic [CNT_W-1:0] run_reg;
   logic [CNT_W-1:0] run_next;
   logic hit_next;

   // nonzero sample restarts the run and drops the flag at once
   assign run_next = !sample_is_zero ? '0 :
                     (run_reg == LAST) ? run_reg : run_reg + 1'b1;
   assign hit_next = sample_is_zero && (run_reg == LAST);

   // only sample strobes advance the run
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_reg <= '0;
         zero_hit <= 1'b0;
      end else if (sample_strobe) begin
         run_reg <= run_next;
         zero_hit <= hit_next;
      end
   end
endmodule

/* test/dac_audio_input_monitor.sv */
// port-level assertions for the audio input front end
`timescale 1ns/1ps
module dac_audio_input_monitor
   import dac_front_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire sample_pair_type dac_samples,
   input wire logic sample_strobe,
   input wire logic init_active,
   input wire logic processing_held,
   input wire logic left_zero_flag,
   input wire logic right_zero_flag,
   input wire logic common_zero_flag
);
   logic common_reg;
   wire status_rd = reg_rd && reg_addr == ADDR_STATUS;

   // shadow of the common select bit, tracked from the register port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         common_reg <= 1'b0;
      else if (reg_wr && reg_addr == ADDR_CONTROL)
         common_reg <= reg_wdata[CTRL_COMMON_BIT];
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // output side during init and hold, and strobe spacing
   a_init_mutes_out: assert property (init_active |-> dac_samples == '0)
      else $error("samples not zero in init");
   a_init_is_held: assert property (init_active |-> processing_held)
      else $error("init without hold");
   a_held_no_strobe: assert property (processing_held [*2] |-> !sample_strobe)
      else $error("strobe while held");
   a_held_zero_out: assert property (processing_held && $past(processing_held) |-> dac_samples == '0)
      else $error("samples not zero while held");
   a_strobe_isolated: assert property (sample_strobe |=> !sample_strobe [*8])
      else $error("strobe too long");
   // register port answers
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data without read");
   a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_run_code_valid: assert property (status_rd && !processing_held |=> reg_rdata[5:4] == 2'b11 && reg_rdata[2:0] != RATIO_NONE)
      else $error("run status wrong");
   a_init_code: assert property (status_rd && init_active |=> reg_rdata[5:4] == 2'b00)
      else $error("init status wrong");
   // common select mirrors the shared flag once settled
   a_common_mirror: assert property (common_reg [*3] |-> left_zero_flag == common_zero_flag && right_zero_flag == common_zero_flag)
      else $error("flags not common");
endmodule

bind dac_audio_input dac_audio_input_monitor mon_inst (.clk, .sys_rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dac_samples,
   .sample_strobe, .init_active, .processing_held, .left_zero_flag,
   .right_zero_flag, .common_zero_flag);

/* test/audio_source_model.sv */
// behavioural serial audio source: master, bit and word clocks plus data
`timescale 1ns/1ps
module audio_source_model
   import dac_front_pkg::*;
#(
   parameter real BIT_NS = 125.0
) (
   input wire logic run,
   input wire logic [1:0] style,
   input wire logic [3:0] mult,
   input wire sample_pair_type pair,
   output logic master_clock,
   output logic serial_bit_clock,
   output logic channel_word_clock,
   output logic serial_data,
   output logic sent
);
   sample_pair_type cur;

   // half frame of 32 bit clocks; data moves on the falling edge
   task automatic half(input logic [23:0] v, input logic lvl);
      int k;
      channel_word_clock = lvl;
      for (int i = 0; i < 32; i++) begin
         k = i - (style == 2'd0 ? 0 : style == 2'd1 ? 1 : 8);
         serial_data = (k >= 0 && k < 24) ? v[23-k] : ~serial_data;
         #(BIT_NS / 2) serial_bit_clock = 1'b1;
         #(BIT_NS / 2) serial_bit_clock = 1'b0;
      end
   endtask

   initial begin
      serial_bit_clock = 1'b0;
      channel_word_clock = 1'b0;
      serial_data = 1'b0;
      sent = 1'b0;
   end

   // master from the bit timebase, so it stops with the link
   always begin
      master_clock = 1'b0;
      wait (run === 1'b1);
      while (run === 1'b1) #(BIT_NS / mult / 2.0) master_clock = ~master_clock;
   end

   // bit and word clocks stand still once a frame ends with run low, the idle data line keeps toggling
   always begin
      while (run !== 1'b1) #(BIT_NS / 2) serial_data = ~serial_data;
      cur = pair;
      sent = ~sent;
      half(cur.left, style != 2'd1);
      half(cur.right, style == 2'd1);
   end
endmodule

/* test/dac_audio_input_tb.sv */
// self-checking bench for the audio input front end
`timescale 1ns/1ps
module dac_audio_input_tb;
   import dac_front_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   sample_pair_type dac_samples, prev, pair = '0;
   logic sample_strobe, init_active, processing_held;
   logic left_zero_flag, right_zero_flag, common_zero_flag;
   logic master_clock, serial_bit_clock, channel_word_clock, serial_data;
   logic sent;
   logic run = 1'b0;
   logic [1:0] style = 2'd0;
   logic [3:0] mult = 4'd4;
   logic expect_on = 1'b0;
   sample_pair_type q[$];
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'h22c7;
   framing_type fmts[3] = '{FMT_LJ24, FMT_I2S, FMT_RJ24};
   logic [3:0] mults[3] = '{4'd4, 4'd2, 4'd3};
   logic [2:0] codes[3] = '{3'd2, 3'd0, 3'd1};

   dac_audio_input #(.INIT_CYCLES(8), .ZERO_RUN(4)) dac_audio_input_inst (
      .clk, .sys_rst, .master_clock, .serial_bit_clock, .channel_word_clock,
      .serial_data, .framing_select_pin(1'b0), .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .dac_samples, .sample_strobe,
      .init_active, .processing_held, .left_zero_flag, .right_zero_flag,
      .common_zero_flag);
   audio_source_model audio_source_model_inst (.run, .style, .mult, .pair,
      .master_clock, .serial_bit_clock, .channel_word_clock, .serial_data,
      .sent);

   always #5 clk = ~clk;

   task automatic chk(input string n, input logic [47:0] s, e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data is only valid in the cycle right after the strobe
   task automatic rd(input string n, input logic [3:0] a,
      input logic [31:0] m, e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, 48'(reg_rdata & m), 48'(e));
   endtask

   // new pair after each frame start; forced lsb keeps nonzero words nonzero
   task automatic frames(input int n, input bit zl, input bit zr);
      repeat (n) begin
         @(sent);
         @(posedge clk);
         pair.left <= zl ? 24'h0 : 24'($random(seed) | 1);
         pair.right <= zr ? 24'h0 : 24'($random(seed) | 1);
      end
   endtask

   task automatic flags(input logic l, r, c);
      repeat (100) @(posedge clk);
      chk("left flag", 48'(left_zero_flag), 48'(l));
      chk("right flag", 48'(right_zero_flag), 48'(r));
      chk("common flag", 48'(common_zero_flag), 48'(c));
   endtask

   // note the frame that just ended; its pair strobes out next
   always @(sent) begin
      if (expect_on)
         q.push_back(prev);
      prev = pair;
   end

   // oldest note against each completed pair
   always @(posedge clk)
      if (sample_strobe === 1'b1 && q.size() > 0)
         chk("samples", dac_samples, q.pop_front());

   // hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial begin
      int n;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("init", 48'(init_active), 48'h1);
      chk("init out", dac_samples, 48'h0);
      rd("ctrl", ADDR_CONTROL, 32'h37, 32'h5);
      rd("state", ADDR_STATUS, 32'h30, 32'h0);
      rd("unmapped", 4'h2, '1, 32'h0);
      // each framing at its own ratio, with a stall before it
      for (int i = 0; i < 3; i++) begin
         expect_on = 1'b0;
         run <= 1'b0;
         repeat (1000) @(posedge clk);
         chk("held", 48'(processing_held), 48'h1);
         wr(ADDR_CONTROL, 32'(fmts[i]));
         rd("ctrl", ADDR_CONTROL, 32'h37, 32'(fmts[i]));
         style <= 2'(i);
         mult <= mults[i];
         run <= 1'b1;
         n = 0;
         // power-up also spends init and one partial frame first
         while (processing_held !== 1'b0 && n < 3300) begin
            @(posedge clk);
            n++;
         end
         chk("resync", 48'(n < (i == 0 ? 3300 : 2400)), 48'h1);
         rd("status", ADDR_STATUS, 32'h37, 32'h30 | codes[i]);
         frames(1, 0, 0);
         expect_on = 1'b1;
         frames(4, 0, 0);
      end
      // zero runs, polarity and common select on the running link
      frames(7, 1, 0);
      flags(1, 0, 0);
      wr(ADDR_CONTROL, 32'(1 << CTRL_INV_BIT));
      flags(0, 1, 1);
      wr(ADDR_CONTROL, 32'(1 << CTRL_COMMON_BIT));
      frames(7, 1, 1);
      flags(1, 1, 1);
      frames(3, 0, 0);
      flags(0, 0, 0);
      expect_on = 1'b0;
      repeat (200) @(posedge clk);
      chk("pending", 48'(q.size()), 48'h0);
      tally_and_finish();
   end
endmodule
